// [shared/xbar_pkg.sv]
package xbar_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NUM_MASTERS     = 8;
	localparam int NUM_WINDOWS     = 8;
	localparam int ADDR_W          = 64;
	localparam int REG_AW          = 12;
	localparam int DATA_W          = 32;
	localparam int BASE_ALIGN_BITS = 10;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int         SEL_CTRL_BIT = 11;
	localparam logic [11:0] OFS_CTRL    = 12'h800;
	localparam logic [11:0] OFS_STATUS  = 12'h804;
	localparam logic [1:0]  REG_BASE    = 2'h0;
	localparam logic [1:0]  REG_MASK    = 2'h1;
	localparam logic [1:0]  REG_MAP     = 2'h2;
	localparam int          CTRL_NODE_LSB = 0;
	localparam int          CTRL_SEL_LSB  = 8;
	localparam int          STAT_EN_LSB   = 0;
	localparam int          STAT_DEF_LSB  = 8;
	localparam logic [63:0] WIN_RESET  = 64'h0;
	localparam logic [3:0]  NODE_RESET = 4'h0;
	localparam logic [1:0]  SEL_RESET  = 2'h0;

	// ----------------------------------------------------------------
	// Map register fields and default route
	// ----------------------------------------------------------------
	localparam int MAP_FETCH_BIT = 4;
	localparam int MAP_BLOCK_BIT = 5;
	localparam int MAP_EN_BIT    = 7;
	localparam int NODE_LSB      = 44;
	localparam int REGION_LSB    = 41;
	localparam logic [3:0] WIN_DEFAULT  = 4'h8;
	localparam logic [2:0] MPORT_CORE0  = 3'h0;
	localparam logic [2:0] MPORT_LINK0  = 3'h6;
	localparam logic [2:0] MPORT_LINK1  = 3'h7;
	localparam logic [2:0] SPORT_SLICE0 = 3'h0;
	localparam logic [2:0] SPORT_LINK0  = 3'h6;
	localparam logic [2:0] SPORT_LINK1  = 3'h7;
	// Slice hash bit per select value: 0 steps 0x020, 2 steps 0x400
	localparam logic [3:0][5:0] SLICE_LSB_TAB = {6'h0c, 6'h0a, 6'h07, 6'h05};

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef logic [NUM_WINDOWS-1:0][ADDR_W-1:0] win_arr_t;
	typedef win_arr_t [NUM_MASTERS-1:0]        cfg_arr_t;

	typedef struct packed {
		logic              valid;
		logic [2:0]        port;
		logic [ADDR_W-1:0] addr;
		logic [3:0]        window;
		logic              denied;
	} rsp_t;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic logic window_hit(input logic [63:0] a, input logic [63:0] b,
		input logic [63:0] m, input logic [63:0] p);
		return p[MAP_EN_BIT] && ((a & m) == b);
	endfunction

	function automatic logic [3:0] first_hit(input logic [63:0] a, input win_arr_t b,
		input win_arr_t m, input win_arr_t p);
		logic [3:0] w;
		w = WIN_DEFAULT;
		// Lowest index written last so it wins
		for (int i = NUM_WINDOWS - 1; i >= 0; i--) begin
			if (window_hit(a, b[i], m[i], p[i])) begin
				w = 4'(i);
			end
		end
		return w;
	endfunction

	function automatic logic [63:0] xlate(input logic [63:0] a, input logic [63:0] m,
		input logic [63:0] p);
		return (a & ~m) | (p & m);
	endfunction

	function automatic logic [2:0] default_port(input logic [63:0] a, input logic [3:0] node,
		input logic [1:0] sel);
		logic [63:0] sh;
		sh = a >> SLICE_LSB_TAB[sel];
		if (a[NODE_LSB +: 4] != node) begin
			return SPORT_LINK0;
		end
		if (a[REGION_LSB + 1 +: 2] != 2'h3) begin
			return SPORT_SLICE0 | {1'b0, sh[1:0]};
		end
		return a[REGION_LSB] ? SPORT_LINK1 : SPORT_LINK0;
	endfunction

	function automatic logic [31:0] half_of(input logic [63:0] v, input logic hi);
		return hi ? v[63:32] : v[31:0];
	endfunction

	function automatic logic [63:0] put_half(input logic [63:0] v, input logic hi,
		input logic [31:0] d);
		return hi ? {d, v[31:0]} : {v[63:32], d};
	endfunction

endpackage

// [shared/win_cfg_if.sv]
`timescale 1ns/1ps
interface win_cfg_if;
	xbar_pkg::cfg_arr_t base;
	xbar_pkg::cfg_arr_t mask;
	xbar_pkg::cfg_arr_t map;
	logic [3:0]         node;
	logic [1:0]         sel;

	modport src (output base, output mask, output map, output node, output sel);
	modport dec (input base, input mask, input map, input node, input sel);
endinterface

// [hdl/window_decoder.sv]
`timescale 1ns/1ps
module window_decoder #(
	parameter int MASTER       = 0,
	parameter bit SECOND_LEVEL = 1'b0
) (
	input  wire logic          clk,
	input  wire logic          rst,
	win_cfg_if.dec             cfg,
	input  wire logic          req_valid,
	input  wire logic [63:0]   req_addr,
	input  wire logic          req_fetch,
	input  wire logic          req_block_read,
	output xbar_pkg::rsp_t     rsp
);

	xbar_pkg::rsp_t st_q;
	xbar_pkg::rsp_t st_d;
	logic [3:0]     win;
	logic [63:0]    map_w;

	// ----------------------------------------------------------------
	// Decode, one cycle from request to answer
	// ----------------------------------------------------------------
	always_comb begin
		win   = xbar_pkg::first_hit(req_addr, cfg.base[MASTER], cfg.mask[MASTER],
			cfg.map[MASTER]);
		map_w = cfg.map[MASTER][win[2:0]];
		st_d  = '0;
		if (req_valid) begin
			st_d.valid  = 1'b1;
			st_d.window = win;
			if (win == xbar_pkg::WIN_DEFAULT) begin
				st_d.port = xbar_pkg::default_port(req_addr, cfg.node, cfg.sel);
				st_d.addr = req_addr;
			end else begin
				st_d.port = map_w[2:0];
				st_d.addr = xbar_pkg::xlate(req_addr, cfg.mask[MASTER][win[2:0]], map_w);
				// First level relies on software leaving both permits set
				st_d.denied = SECOND_LEVEL &&
					((req_fetch && !map_w[xbar_pkg::MAP_FETCH_BIT]) ||
					(req_block_read && !map_w[xbar_pkg::MAP_BLOCK_BIT]));
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign rsp = st_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	deny_fetch_a: assert property (req_valid && req_fetch && SECOND_LEVEL
		&& win != xbar_pkg::WIN_DEFAULT && !map_w[xbar_pkg::MAP_FETCH_BIT]
		|=> rsp.valid && rsp.denied)
		else $error("fetch through closed window not denied");
	first_no_deny_a: assert property (!SECOND_LEVEL |-> !rsp.denied)
		else $error("denial seen on first level");

	deny_c: cover property (rsp.valid && rsp.denied);

endmodule

// [hdl/crossbar_address_window_router.sv]
`timescale 1ns/1ps
// Functional notes
// - Every master port owns eight separately programmed address windows.
// - A window is three 64-bit registers: base, mask and target map.
// - Base is 1KB aligned; its low ten bits are always zero.
// - Map bits 2 to 0 pick the slave port for a hit.
// - Map bit 4 permits instruction fetch, bit 5 permits block reads.
// - Map bit 7 enables the window; a disabled window never hits.
// - Hit when address AND mask equals base.
// - Outgoing address keeps unmasked address bits, takes masked bits from map.
// - Second level refuses fetch or block reads through windows lacking permits.
// - Window 0 wins over window 7; default route ranks last.
// - Default route is hidden and used only when no window hits.
// - Each master port decodes only its own windows.
// - Masters 0 to 3 are cores, 6 and 7 the link controllers.
// - Slaves 0 to 3 are cache slices, 6 and 7 the link controllers.
// - Addresses of another node go to link controller 0.
// - Local low memory is hashed over four slices by the select setting.
// - Local 0x0C.. to 0x0D.. to link 0, 0x0E.. to 0x0F.. to link 1.
module crossbar_address_window_router #(
	parameter bit SECOND_LEVEL = 1'b0
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [11:0]      reg_addr,
	input  wire logic [31:0]      reg_wdata,
	input  wire logic             reg_write,
	input  wire logic             reg_read,
	output logic      [31:0]      reg_rdata,
	input  wire logic [7:0]       req_valid,
	input  wire logic [7:0][63:0] req_addr,
	input  wire logic [7:0]       req_fetch,
	input  wire logic [7:0]       req_block_read,
	output logic      [7:0]       rsp_valid,
	output logic      [7:0][2:0]  rsp_port,
	output logic      [7:0][63:0] rsp_addr,
	output logic      [7:0][3:0]  rsp_window,
	output logic      [7:0]       rsp_denied
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		xbar_pkg::cfg_arr_t base;
		xbar_pkg::cfg_arr_t mask;
		xbar_pkg::cfg_arr_t map;
		logic [3:0]         node;
		logic [1:0]         sel;
		logic [7:0]         last_default;
		logic [31:0]        rdata;
	} regs_t;

	regs_t              st_q;
	regs_t              st_d;
	xbar_pkg::rsp_t     rsp [xbar_pkg::NUM_MASTERS];
	logic [7:0]         en_any;
	logic [2:0]         wm;
	logic [2:0]         ww;
	logic [1:0]         wr;
	logic               hf;
	logic [31:0]        rd_val;

	win_cfg_if cfg ();

	assign cfg.base = st_q.base;
	assign cfg.mask = st_q.mask;
	assign cfg.map  = st_q.map;
	assign cfg.node = st_q.node;
	assign cfg.sel  = st_q.sel;

	// ----------------------------------------------------------------
	// Status view
	// ----------------------------------------------------------------
	always_comb begin
		en_any = '0;
		for (int m = 0; m < xbar_pkg::NUM_MASTERS; m++) begin
			for (int w = 0; w < xbar_pkg::NUM_WINDOWS; w++) begin
				en_any[m] = en_any[m] | st_q.map[m][w][xbar_pkg::MAP_EN_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// Register access
	// ----------------------------------------------------------------
	always_comb begin
		wm     = reg_addr[10:8];
		ww     = reg_addr[7:5];
		wr     = reg_addr[4:3];
		hf     = reg_addr[2];
		rd_val = '0;
		if (!reg_addr[xbar_pkg::SEL_CTRL_BIT]) begin
			unique case (wr)
				xbar_pkg::REG_BASE: begin
					rd_val = xbar_pkg::half_of(st_q.base[wm][ww], hf);
				end
				xbar_pkg::REG_MASK: begin
					rd_val = xbar_pkg::half_of(st_q.mask[wm][ww], hf);
				end
				xbar_pkg::REG_MAP: begin
					rd_val = xbar_pkg::half_of(st_q.map[wm][ww], hf);
				end
				default: begin
					rd_val = '0;
				end
			endcase
		end else if (reg_addr[11:2] == xbar_pkg::OFS_CTRL[11:2]) begin
			rd_val[xbar_pkg::CTRL_NODE_LSB +: 4] = st_q.node;
			rd_val[xbar_pkg::CTRL_SEL_LSB +: 2]  = st_q.sel;
		end else if (reg_addr[11:2] == xbar_pkg::OFS_STATUS[11:2]) begin
			rd_val[xbar_pkg::STAT_EN_LSB +: 8]  = en_any;
			rd_val[xbar_pkg::STAT_DEF_LSB +: 8] = st_q.last_default;
		end
	end

	always_comb begin
		st_d       = st_q;
		st_d.rdata = reg_read ? rd_val : '0;
		if (reg_write && !reg_addr[xbar_pkg::SEL_CTRL_BIT]) begin
			unique case (wr)
				xbar_pkg::REG_BASE: begin
					st_d.base[wm][ww] = xbar_pkg::put_half(st_q.base[wm][ww], hf, reg_wdata);
					// Low bits cannot be stored, so no window is finer than 1KB
					st_d.base[wm][ww][xbar_pkg::BASE_ALIGN_BITS-1:0] = '0;
				end
				xbar_pkg::REG_MASK: begin
					st_d.mask[wm][ww] = xbar_pkg::put_half(st_q.mask[wm][ww], hf, reg_wdata);
				end
				xbar_pkg::REG_MAP: begin
					st_d.map[wm][ww] = xbar_pkg::put_half(st_q.map[wm][ww], hf, reg_wdata);
				end
				default: begin
				end
			endcase
		end
		if (reg_write && reg_addr[11:2] == xbar_pkg::OFS_CTRL[11:2]) begin
			// Changing sel after caching starts reshuffles slices
			st_d.node = reg_wdata[xbar_pkg::CTRL_NODE_LSB +: 4];
			st_d.sel  = reg_wdata[xbar_pkg::CTRL_SEL_LSB +: 2];
		end
		for (int m = 0; m < xbar_pkg::NUM_MASTERS; m++) begin
			if (rsp[m].valid) begin
				st_d.last_default[m] = rsp[m].window == xbar_pkg::WIN_DEFAULT;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_q              <= '0;
			st_q.base         <= {(xbar_pkg::NUM_MASTERS * xbar_pkg::NUM_WINDOWS){xbar_pkg::WIN_RESET}};
			st_q.mask         <= {(xbar_pkg::NUM_MASTERS * xbar_pkg::NUM_WINDOWS){xbar_pkg::WIN_RESET}};
			st_q.map          <= {(xbar_pkg::NUM_MASTERS * xbar_pkg::NUM_WINDOWS){xbar_pkg::WIN_RESET}};
			st_q.node         <= xbar_pkg::NODE_RESET;
			st_q.sel          <= xbar_pkg::SEL_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	assign reg_rdata = st_q.rdata;

	// ----------------------------------------------------------------
	// Per-port decoders
	// ----------------------------------------------------------------
	// Ports 4 and 5 have no master on the first level but decode all the same
	for (genvar m = 0; m < xbar_pkg::NUM_MASTERS; m++) begin : g_port
		window_decoder #(
			.MASTER       (m),
			.SECOND_LEVEL (SECOND_LEVEL)
		) u_dec (
			.clk            (clk),
			.rst            (rst),
			.cfg            (cfg),
			.req_valid      (req_valid[m]),
			.req_addr       (req_addr[m]),
			.req_fetch      (req_fetch[m]),
			.req_block_read (req_block_read[m]),
			.rsp            (rsp[m])
		);

		assign rsp_valid[m]  = rsp[m].valid;
		assign rsp_port[m]   = rsp[m].port;
		assign rsp_addr[m]   = rsp[m].addr;
		assign rsp_window[m] = rsp[m].window;
		assign rsp_denied[m] = rsp[m].denied;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Settings a response was decoded with; $past cannot be indexed by the present window
	xbar_pkg::cfg_arr_t map_p_q;
	xbar_pkg::cfg_arr_t mask_p_q;

	always_ff @(posedge clk) begin
		map_p_q  <= st_q.map;
		mask_p_q <= st_q.mask;
	end

	rd_idle_a: assert property (!reg_read |=> reg_rdata == 32'h0)
		else $error("read data outside read answer cycle");
	mask_rdback_a: assert property (reg_write && !reg_addr[11] && reg_addr[4:3] == 2'h1
		##1 reg_read && reg_addr == $past(reg_addr)
		|=> reg_rdata == $past(reg_wdata, 2))
		else $error("mask half did not read back");
	base_align_a: assert property (reg_read && !reg_addr[11] && reg_addr[4:2] == 3'h0
		|=> reg_rdata[9:0] == 10'h0)
		else $error("base low bits not zero");
	ctrl_rdback_a: assert property (reg_write && reg_addr == 12'h800
		##1 reg_read && reg_addr == 12'h800
		|=> reg_rdata[3:0] == $past(reg_wdata[3:0], 2)
		&& reg_rdata[9:8] == $past(reg_wdata[9:8], 2))
		else $error("control fields did not read back");

	for (genvar m = 0; m < xbar_pkg::NUM_MASTERS; m++) begin : g_chk
		one_cycle_a: assert property (req_valid[m] |=> rsp_valid[m])
			else $error("answer not one cycle after request");
		no_req_a: assert property (!req_valid[m] |=> !rsp_valid[m])
			else $error("answer without request");
		win_ref_a: assert property (rsp_valid[m] |-> rsp_window[m] ==
			xbar_pkg::first_hit($past(req_addr[m]), $past(st_q.base[m]),
			$past(st_q.mask[m]), $past(st_q.map[m])))
			else $error("wrong winning window");
		none_en_a: assert property (rsp_valid[m] && $past(!en_any[m])
			|-> rsp_window[m] == 4'h8)
			else $error("hit with all windows disabled");
		def_port_a: assert property (rsp_valid[m] && rsp_window[m] == 4'h8
			|-> rsp_port[m] == xbar_pkg::default_port($past(req_addr[m]),
			$past(st_q.node), $past(st_q.sel)) && rsp_addr[m] == $past(req_addr[m]))
			else $error("default route wrong");
		remote_a: assert property (req_valid[m] && req_addr[m][47:44] != st_q.node
			&& xbar_pkg::first_hit(req_addr[m], st_q.base[m], st_q.mask[m], st_q.map[m])
			== 4'h8 |=> rsp_port[m] == 3'h6)
			else $error("remote node not sent to link 0");
		win_map_a: assert property (rsp_valid[m] && rsp_window[m] != 4'h8
			|-> rsp_port[m] == map_p_q[m][rsp_window[m][2:0]][2:0])
			else $error("window port wrong");
		win_addr_a: assert property (rsp_valid[m] && rsp_window[m] != 4'h8
			|-> rsp_addr[m] == (($past(req_addr[m]) & ~mask_p_q[m][rsp_window[m][2:0]])
			| (map_p_q[m][rsp_window[m][2:0]]
			& mask_p_q[m][rsp_window[m][2:0]])))
			else $error("translated address wrong");
	end

	hit_c: cover property (rsp_valid[0] && rsp_window[0] == 4'h0);
	slice_c: cover property (rsp_valid[1] && rsp_window[1] == 4'h8 && rsp_port[1] == 3'h3);
	link1_c: cover property (rsp_valid[6] && rsp_window[6] == 4'h8 && rsp_port[6] == 3'h7);
	cfg_c: cover property (reg_write ##1 req_valid[0]);

endmodule

// [bench/slave_side_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Slave side: takes every routed request at once
// ----------------------------------------------------------------
// Slaves never stall, so a plain count of arrivals is all it keeps
module slave_side_model (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  rsp_valid,
	output logic      [31:0] taken_cnt
);
	always_ff @(posedge clk) begin
		if (rst) begin
			taken_cnt <= 32'h0;
		end else begin
			taken_cnt <= taken_cnt + 32'($countones(rsp_valid));
		end
	end
endmodule

// [bench/crossbar_address_window_router_tb.sv]
`timescale 1ns/1ps
module crossbar_address_window_router_tb;
	logic             clk;
	logic             rst;
	logic [11:0]      reg_addr;
	logic [31:0]      reg_wdata;
	logic             reg_write;
	logic             reg_read;
	logic [31:0]      reg_rdata;
	logic [7:0]       req_valid;
	logic [7:0][63:0] req_addr;
	logic [7:0]       req_fetch;
	logic [7:0]       req_block_read;
	logic [7:0]       rsp_valid;
	logic [7:0][2:0]  rsp_port;
	logic [7:0][63:0] rsp_addr;
	logic [7:0][3:0]  rsp_window;
	logic [7:0]       rsp_denied;
	logic [31:0]      taken_cnt;
	logic [63:0]      sbase [8][8];
	logic [63:0]      smask [8][8];
	logic [63:0]      smap  [8][8];
	logic [3:0]       node;
	logic [1:0]       sel;
	xbar_pkg::rsp_t   exp_q [8][$];
	int               due_q [8][$];
	int               mcyc;
	int               cycles;
	int               issued;
	int               num_errors;
	int               n_compared;

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	crossbar_address_window_router #(.SECOND_LEVEL(1'b1)) dut_u (
		.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
		.req_valid(req_valid), .req_addr(req_addr), .req_fetch(req_fetch),
		.req_block_read(req_block_read), .rsp_valid(rsp_valid), .rsp_port(rsp_port),
		.rsp_addr(rsp_addr), .rsp_window(rsp_window), .rsp_denied(rsp_denied)
	);

	slave_side_model peer_u (
		.clk(clk), .rst(rst), .rsp_valid(rsp_valid), .taken_cnt(taken_cnt)
	);

	// ----------------------------------------------------------------
	// Checking and reference decode
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	function automatic xbar_pkg::rsp_t model(int m, logic [63:0] a, logic f, logic b);
		xbar_pkg::rsp_t r;
		int lsb [4];
		lsb = '{5, 7, 10, 12};
		r = '0;
		r.valid = 1'b1;
		r.window = 4'h8;
		r.addr = a;
		if (a[47:44] != node) r.port = 3'h6;
		else if (a[43:42] != 2'h3) r.port = {1'b0, 2'(a >> lsb[sel])};
		else r.port = a[41] ? 3'h7 : 3'h6;
		// Walk downward so the lowest hitting window is left standing
		for (int i = 7; i >= 0; i--) begin
			if (smap[m][i][7] && (a & smask[m][i]) == sbase[m][i]) begin
				r.window = 4'(i);
				r.port = smap[m][i][2:0];
				r.addr = (a & ~smask[m][i]) | (smap[m][i] & smask[m][i]);
				r.denied = (f && !smap[m][i][4]) || (b && !smap[m][i][5]);
			end
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Drivers
	// ----------------------------------------------------------------
	task automatic reg_wr(input logic [11:0] a, input logic [31:0] d);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_write <= 1'b0;
		@(posedge clk);
	endtask

	task automatic reg_rd(input logic [11:0] a, input logic [31:0] exp);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_read <= 1'b0;
		#1;
		check("reg_rdata", {32'h0, reg_rdata}, {32'h0, exp});
		@(posedge clk);
	endtask

	task automatic win_wr(input int m, input int w, input int r, input logic [63:0] v);
		logic [11:0] a;
		a = 12'(m * 'h100 + w * 'h20 + r * 8);
		reg_wr(a, v[31:0]);
		reg_wr(a + 12'h4, v[63:32]);
		if (r == 0) sbase[m][w] = v & ~64'h3ff;
		else if (r == 1) smask[m][w] = v;
		else smap[m][w] = v;
	endtask

	task automatic ctrl_wr(input logic [3:0] n, input logic [1:0] s);
		reg_wr(12'h800, {22'h0, s, 4'h0, n});
		node = n;
		sel = s;
	endtask

	task automatic send(input logic [7:0] v, input logic [7:0][63:0] a, input logic [7:0] f,
		input logic [7:0] b);
		for (int m = 0; m < 8; m++) begin
			if (v[m]) begin
				exp_q[m].push_back(model(m, a[m], f[m], b[m]));
				due_q[m].push_back(mcyc + 2);
				issued++;
			end
		end
		req_valid <= v;
		req_addr <= a;
		req_fetch <= f;
		req_block_read <= b;
		@(posedge clk);
	endtask

	// ----------------------------------------------------------------
	// Monitor: answers must land exactly one cycle after the request
	// ----------------------------------------------------------------
	initial begin
		mcyc = 0;
		forever begin
			@(posedge clk);
			#1;
			mcyc++;
			for (int m = 0; m < 8; m++) begin
				if (due_q[m].size() > 0 && due_q[m][0] == mcyc) begin
					xbar_pkg::rsp_t e;
					e = exp_q[m].pop_front();
					void'(due_q[m].pop_front());
					check("rsp_valid", 64'(rsp_valid[m]), 64'h1);
					check("rsp_window", 64'(rsp_window[m]), 64'(e.window));
					check("rsp_port", 64'(rsp_port[m]), 64'(e.port));
					check("rsp_addr", rsp_addr[m], e.addr);
					check("rsp_denied", 64'(rsp_denied[m]), 64'(e.denied));
				end else if (rsp_valid[m] !== 1'b0) begin
					check("stray rsp_valid", 64'(rsp_valid[m]), 64'h0);
				end
			end
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			give_verdict();
		end
	end

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		logic [7:0][63:0] a;
		logic [63:0]      mk;
		logic [63:0]      bs;
		logic [63:0]      tbl [15];
		logic [63:0]      t3 [6];
		rst = 1'b1;
		reg_addr = '0;
		reg_wdata = '0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		req_valid = '0;
		req_addr = '0;
		req_fetch = '0;
		req_block_read = '0;
		node = 4'h0;
		sel = 2'h0;
		a = '0;
		for (int m = 0; m < 8; m++) begin
			for (int w = 0; w < 8; w++) begin
				sbase[m][w] = '0;
				smask[m][w] = '0;
				smap[m][w] = '0;
			end
		end
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		void'($urandom(20));
		reg_rd(12'h010, 32'h0);
		reg_rd(12'h7f4, 32'h0);
		reg_rd(12'h800, 32'h0);
		reg_wr(12'h018, 32'hffff_ffff);
		reg_rd(12'h018, 32'h0);
		reg_rd(12'h808, 32'h0);
		win_wr(0, 0, 0, 64'h1000_03ff);
		reg_rd(12'h000, 32'h1000_0000);
		$display("test 1 done");
		tbl = '{64'h3000_0000_0000, 64'h0c00_0000_0000, 64'h0dff_ffff_ffff,
			64'h0e00_0000_0000, 64'h0fff_ffff_ffff, 64'h0bff_ffff_ffff, 64'h0, 64'h20,
			64'h40, 64'h60, 64'h400, 64'h800, 64'hc00, 64'h1080, 64'hffff_0000_0000_0060};
		// Every select with nodes 0 to 3; nothing enabled yet so all goes the default way
		for (int s = 0; s < 4; s++) begin
			ctrl_wr(4'(s), 2'(s));
			for (int i = 0; i < 15; i++) begin
				for (int m = 0; m < 8; m++) begin
					a[m] = m[0] ? tbl[i] : (tbl[i] | (64'(s) << 44));
				end
				send(8'hff, a, 8'h0, 8'h0);
			end
			send(8'h00, a, 8'h0, 8'h0);
		end
		$display("test 2 done");
		ctrl_wr(4'h0, 2'h2);
		win_wr(0, 0, 1, 64'hffff_ffff_f000_0000);
		win_wr(0, 0, 2, 64'h1000_0082);
		win_wr(0, 1, 0, 64'h1000_0000);
		win_wr(0, 1, 1, 64'hffff_ffff_fff0_0000);
		win_wr(0, 1, 2, 64'h2030_00b1);
		win_wr(0, 2, 0, 64'h2000_0000);
		win_wr(0, 2, 1, 64'hffff_ffff_f000_0000);
		win_wr(0, 2, 2, 64'h0abc_0000_0037);
		win_wr(0, 3, 0, 64'h2000_0000);
		win_wr(0, 3, 1, 64'hffff_ffff_f000_0000);
		win_wr(0, 3, 2, 64'h5000_00f3);
		win_wr(0, 7, 2, 64'hb6);
		t3 = '{64'h1000_0000, 64'h100f_ffff, 64'h1fff_fffc, 64'h2000_0040, 64'h2fff_ffff,
			64'h0c00_0000_0000};
		// Master 1 has no windows and must not see those of master 0
		for (int i = 0; i < 6; i++) begin
			for (int j = 0; j < 4; j++) begin
				a[0] = t3[i];
				a[1] = t3[i];
				send(8'h03, a, {6'h0, {2{j[0]}}}, {6'h0, {2{j[1]}}});
			end
		end
		send(8'h00, a, 8'h0, 8'h0);
		$display("test 3 done");
		// A write at the request's own edge only affects later requests
		a[0] = 64'h5000;
		reg_write <= 1'b1;
		reg_addr <= 12'h0f0;
		reg_wdata <= 32'h36;
		send(8'h01, a, 8'h0, 8'h0);
		reg_write <= 1'b0;
		smap[0][7] = 64'h36;
		send(8'h01, a, 8'h0, 8'h0);
		send(8'h00, a, 8'h0, 8'h0);
		$display("test 4 done");
		// Windows set before traffic, identity mapping with both permits on
		for (int m = 1; m < 8; m++) begin
			for (int w = 0; w < 8; w++) begin
				mk = {$urandom, $urandom} & 64'h0000_0300_0000_0c00;
				bs = {$urandom, $urandom} & mk;
				win_wr(m, w, 0, bs);
				win_wr(m, w, 1, mk);
				win_wr(m, w, 2, bs | 64'h30 | 64'($urandom_range(0, 7)) |
					(($urandom_range(0, 3) != 0) ? 64'h80 : 64'h0));
			end
		end
		// Select stays put while traffic flows
		for (int k = 0; k < 300; k++) begin
			for (int m = 0; m < 8; m++) begin
				a[m] = {16'($urandom), 4'($urandom_range(0, 1)), 4'($urandom),
					8'($urandom_range(0, 3)), 32'($urandom)};
			end
			send(8'($urandom), a, 8'($urandom), 8'($urandom));
		end
		send(8'h00, a, 8'h0, 8'h0);
		repeat (3) @(posedge clk);
		check("taken_cnt", 64'(taken_cnt), 64'(issued));
		$display("test 5 done");
		give_verdict();
	end
endmodule
